// [hdl/content_protection_control.sv]
`timescale 1ns/1ps
`default_nettype none
module content_protection_control
	import protection_pkg::*;
(
	input wire logic clock, // 40 MHz internal clock
	input wire logic rstn, // asynchronous reset, active low
	input wire ctl_req_s req, // register access request
	output logic [7:0] rdata, // read data, valid with rdata_valid
	output logic rdata_valid, // one cycle after a read strobe
	input wire logic [1:0] policy, // encryption policy field
	input wire logic repeater_mode, // transmitter acts as repeater
	input wire logic authenticated, // authentication succeeded
	input wire logic receiver_key_ready, // receiver key has been read
	output engine_cmd_s cmd, // one-cycle engine commands
	output logic auth_enabled, // authentication enabled
	output logic auth_continue, // engine may go past key check
	output video_mode_e video_mode // video path selection
);
	// reset release through two flops
	// assertion is immediate, release waits for the clock so no flop leaves reset late
	logic rst_meta;
	logic rst_sync;
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// decoded write of protection_control
	logic ctl_wr;
	logic [7:0] wd;
	assign ctl_wr = req.wr && (req.addr == CTL_ADDR);
	assign wd = req.wdata;

	// held state and its next values
	logic key_accepted; // receiver_key_accepted
	logic enc_request; // stored encryption_request
	logic enc_suppressed; // encryption forced off
	logic ready_seen; // previous receiver_key_ready
	logic enc_active; // effective request after policy
	logic next_auth_enabled;
	logic next_key_accepted;
	logic next_enc_request;
	logic next_enc_suppressed;
	logic [7:0] next_rdata;
	logic next_rdata_valid;
	engine_cmd_s next_cmd;
	video_mode_e next_video_mode;

	// policy can pin the request high regardless of software
	assign enc_active = enc_request || (policy == POLICY_ALWAYS);
	// a non-repeater stalls until software accepts the key
	assign auth_continue = repeater_mode || key_accepted;

	// next-state for control bits
	always_comb
	begin
		next_auth_enabled = auth_enabled;
		next_key_accepted = key_accepted;
		next_enc_request = enc_request;
		next_enc_suppressed = enc_suppressed;
		next_cmd = '0;
		// key ready edge clears acceptance; a same-cycle set wins
		if (receiver_key_ready && !ready_seen)
			next_key_accepted = 1'b0;
		if (ctl_wr)
		begin
			// the list bit becomes a single pulse, nothing stored
			next_cmd.list_accepted = wd[BIT_LIST];
			// set placed after the clear, so a same-cycle write wins
			if (wd[BIT_KEY])
				next_key_accepted = 1'b1;
			// request bit writes ignored under always-encrypt
			if (policy != POLICY_ALWAYS)
				next_enc_request = wd[BIT_ENC_REQ];
			if (wd[BIT_ENC_REQ] || wd[BIT_ENABLE])
				next_enc_suppressed = 1'b0;
			if (wd[BIT_ENC_OFF])
				next_enc_suppressed = 1'b1;
			if (wd[BIT_ENABLE])
			begin
				next_auth_enabled = 1'b1;
				next_cmd.auth_restart = 1'b1;
			end
			// disable and reset beat enable in the same write
			if (wd[BIT_DISABLE])
			begin
				next_auth_enabled = 1'b0;
				next_cmd.auth_restart = 1'b0;
			end
			if (wd[BIT_RESET])
			begin
				next_auth_enabled = 1'b0;
				next_cmd.auth_restart = 1'b0;
				next_cmd.engine_reset = 1'b1;
			end
		end
	end

	// video selection from effective request and auth state
	always_comb
	begin
		if (!enc_active || enc_suppressed)
			next_video_mode = VIDEO_PLAIN;
		else if (authenticated)
			next_video_mode = VIDEO_ENCRYPTED;
		else
			next_video_mode = VIDEO_BLUE;
	end

	// read path; self-clearing bits always read zero
	always_comb
	begin
		// every read answers, so a stray offset cannot stall the master
		next_rdata_valid = req.rd;
		// reserved bit six falls out of the zero default
		next_rdata = RD_UNMAPPED;
		if (req.rd && req.addr == CTL_ADDR)
		begin
			next_rdata[BIT_KEY] = key_accepted;
			next_rdata[BIT_ENC_REQ] = enc_active;
			next_rdata[BIT_ENABLE] = auth_enabled;
		end
	end

	// registers only
	always_ff @(posedge clock or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			auth_enabled <= CTL_RESET[BIT_ENABLE];
			key_accepted <= CTL_RESET[BIT_KEY];
			enc_request <= CTL_RESET[BIT_ENC_REQ];
			enc_suppressed <= 1'b0;
			ready_seen <= 1'b0;
			cmd <= '0;
			video_mode <= VIDEO_PLAIN;
			rdata <= RD_UNMAPPED;
			rdata_valid <= 1'b0;
		end
		else
		begin
			auth_enabled <= next_auth_enabled;
			key_accepted <= next_key_accepted;
			enc_request <= next_enc_request;
			enc_suppressed <= next_enc_suppressed;
			// edge memory only; a level held high clears acceptance once
			ready_seen <= receiver_key_ready;
			cmd <= next_cmd;
			video_mode <= next_video_mode;
			rdata <= next_rdata;
			rdata_valid <= next_rdata_valid;
		end
	end

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_sync);

	AST_RESET_ACTS: assert property (ctl_wr && wd[BIT_RESET] |=> cmd.engine_reset && !auth_enabled)
		else $error("reset write did not reset engine");
	AST_LIST_PULSE: assert property (ctl_wr && wd[BIT_LIST] |=> cmd.list_accepted)
		else $error("list accepted pulse missing");
	AST_KEY_SET: assert property (ctl_wr && wd[BIT_KEY] |=> key_accepted && auth_continue)
		else $error("key accepted not set");
	AST_KEY_CLEAR: assert property ($rose(receiver_key_ready) && !(ctl_wr && wd[BIT_KEY]) |=> !key_accepted)
		else $error("key ready did not clear acceptance");
	AST_KEY_ZERO: assert property (key_accepted && ctl_wr && !wd[BIT_KEY] && !$rose(receiver_key_ready)
		|=> key_accepted)
		else $error("zero write changed key acceptance");
	// off beats a request in the same byte, so any off write gives plain video
	AST_ENC_OFF: assert property (ctl_wr && wd[BIT_ENC_OFF] |=> ##1 video_mode == VIDEO_PLAIN)
		else $error("encryption off did not give plain video");
	AST_ENCRYPTED: assert property (enc_active && !enc_suppressed && authenticated
		|=> video_mode == VIDEO_ENCRYPTED)
		else $error("encrypted video expected");
	AST_BLUE: assert property (enc_active && !enc_suppressed && !authenticated |=> video_mode == VIDEO_BLUE)
		else $error("blue screen expected");
	AST_PLAIN: assert property (!enc_request && policy != POLICY_ALWAYS |=> video_mode == VIDEO_PLAIN)
		else $error("plain video expected");
	AST_ALWAYS_READ: assert property (req.rd && req.addr == CTL_ADDR && policy == POLICY_ALWAYS
		|=> rdata_valid && rdata[BIT_ENC_REQ])
		else $error("request bit not forced under always policy");
	AST_DISABLE: assert property (ctl_wr && wd[BIT_DISABLE] |=> !auth_enabled && !cmd.auth_restart)
		else $error("disable write did not disable");
	AST_ENABLE: assert property (ctl_wr && wd[BIT_ENABLE] && !wd[BIT_DISABLE] && !wd[BIT_RESET]
		|=> auth_enabled && cmd.auth_restart)
		else $error("enable write did not restart");
	AST_WAIT_KEY: assert property (!repeater_mode && !key_accepted |-> !auth_continue)
		else $error("continued without key acceptance");
	AST_SELF_CLEAR: assert property (rdata_valid |-> !rdata[BIT_RESET] && !rdata[BIT_LIST]
		&& !rdata[BIT_ENC_OFF] && !rdata[BIT_DISABLE])
		else $error("action bit read back nonzero");
	// no write, no command: pulses never linger past one cycle
	AST_NO_WRITE_NO_CMD: assert property (!ctl_wr |=> cmd == '0)
		else $error("engine command without a write");
	// reset wins over a restart asked for in the same byte
	AST_RESET_PRIORITY: assert property (ctl_wr && wd[BIT_RESET] |=> !cmd.auth_restart)
		else $error("restart pulsed alongside engine reset");
	// encryption off must leave the enabled state alone
	AST_ENC_OFF_AUTH: assert property (ctl_wr && wd[BIT_ENC_OFF] && !wd[BIT_ENABLE] && !wd[BIT_DISABLE]
		&& !wd[BIT_RESET] |=> $stable(auth_enabled))
		else $error("encryption off changed authentication state");
	// stored request follows bit two while the policy leaves it writable
	AST_REQ_STORED: assert property (ctl_wr && policy != POLICY_ALWAYS
		|=> enc_request == $past(wd[BIT_ENC_REQ]))
		else $error("request bit not stored");
	// under always-encrypt the stored request must not move
	AST_ALWAYS_HOLD: assert property (policy == POLICY_ALWAYS |=> $stable(enc_request))
		else $error("request bit changed under always policy");
	// a read of the control offset reports the live status bits
	AST_READ_STATUS: assert property (req.rd && req.addr == CTL_ADDR
		|=> rdata_valid && rdata[BIT_ENABLE] == $past(auth_enabled) && rdata[BIT_KEY] == $past(key_accepted))
		else $error("read status mismatch");
endmodule
`default_nettype wire

// [hdl/protection_pkg.sv]
// What this block does
// - reset bit restarts engine, drops authentication
// - list-accepted bit completes authentication, self-clears
// - key-accepted bit lets authentication continue
// - key ready clears key-accepted; zero ignored
// - encryption-off sends plain video, keeps authentication
// - request plus authenticated sends encrypted video
// - request without authentication sends blue screen
// - request clear sends plain video
// - always-encrypt policy forces request bit one
// - disable bit turns authentication off, self-clears
// - bit zero enables or restarts; reads status
// - always-encrypt policy code is two'b10
// - non-repeater waits for key-accepted before continuing
package protection_pkg;
	// register map
	localparam logic [7:0] CTL_ADDR = 8'hC3; // protection_control offset
	localparam logic [7:0] CTL_RESET = 8'h00; // reset value
	localparam logic [7:0] RD_UNMAPPED = 8'h00; // answer for other addresses
	// field positions in protection_control
	localparam int BIT_RESET = 7; // protection_reset
	localparam int BIT_LIST = 5; // downstream_list_accepted
	localparam int BIT_KEY = 4; // receiver_key_accepted
	localparam int BIT_ENC_OFF = 3; // encryption_off_pulse
	localparam int BIT_ENC_REQ = 2; // encryption_request
	localparam int BIT_DISABLE = 1; // authentication_disable
	localparam int BIT_ENABLE = 0; // authentication_enable_restart
	// encryption policy field codes
	localparam logic [1:0] POLICY_ALWAYS = 2'h2; // always encrypt

	// register access request from the serial control bus
	typedef struct packed {
		logic wr; // write strobe, one cycle
		logic rd; // read strobe, one cycle
		logic [7:0] addr; // register offset
		logic [7:0] wdata; // write data
	} ctl_req_s;

	// what the video path sends
	typedef enum logic [1:0] {
		VIDEO_PLAIN,
		VIDEO_ENCRYPTED,
		VIDEO_BLUE
	} video_mode_e;

	// one-cycle commands toward the protection engine
	typedef struct packed {
		logic engine_reset; // reset the transmitter engine
		logic auth_restart; // start or restart authentication
		logic list_accepted; // downstream key list checked
	} engine_cmd_s;
endpackage

// [verif/tb_content_protection_control.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_content_protection_control;
	import protection_pkg::*;
	localparam logic [7:0] A = CTL_ADDR; // short alias for the mapped offset
	logic clock = 1'b0; // 40 MHz
	logic rstn = 1'b0; // active low reset
	ctl_req_s req = '0; // register strobes
	logic [1:0] policy = 2'h0; // encryption policy level
	logic repeater_mode = 1'b0; // repeater level
	logic authenticated = 1'b0; // engine status
	logic receiver_key_ready = 1'b0; // engine key flag
	logic [7:0] rdata; // read answer
	logic rdata_valid; // read answer strobe
	engine_cmd_s cmd; // engine pulses
	logic auth_enabled; // enabled level
	logic auth_continue; // key gate
	video_mode_e video_mode; // video selection
	int error_cnt = 0; // mismatches
	int num_checks = 0; // comparisons
	content_protection_control dut (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
		.rdata_valid(rdata_valid), .policy(policy), .repeater_mode(repeater_mode),
		.authenticated(authenticated), .receiver_key_ready(receiver_key_ready), .cmd(cmd),
		.auth_enabled(auth_enabled), .auth_continue(auth_continue), .video_mode(video_mode));
	// clock, half period 12.5 ns
	initial
	begin
		forever #12.5 clock = ~clock;
	end
	// land just after the edge so inputs never race the sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// leading tick keeps a strobe from being assigned twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		req = '{1'b1, 1'b0, a, d};
		tick(1);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		tick(1);
		req = '{1'b0, 1'b1, a, 8'h00};
		tick(1);
		req.rd = 1'b0;
		`CHK("rdata_valid", 1'b1, rdata_valid)
		`CHK("rdata", e, rdata)
	endtask
	// reset state and unmapped offsets
	task automatic t_reset;
		rd(A, CTL_RESET);
		rd(8'hC4, RD_UNMAPPED);
		wr(8'hC4, 8'h01);
		`CHK("auth_enabled", 1'b0, auth_enabled)
	endtask
	// enable, restart and zero write
	task automatic t_enable;
		wr(A, 8'h01);
		`CHK("auth_restart", 1'b1, cmd.auth_restart)
		tick(1);
		`CHK("auth_restart", 1'b0, cmd.auth_restart)
		rd(A, 8'h01);
		wr(A, 8'h01);
		`CHK("auth_restart", 1'b1, cmd.auth_restart)
		wr(A, 8'h00);
		`CHK("auth_enabled", 1'b1, auth_enabled)
	endtask
	// disable and protection reset, both self-clearing
	task automatic t_off;
		wr(A, 8'h02);
		`CHK("auth_enabled", 1'b0, auth_enabled)
		rd(A, 8'h00);
		wr(A, 8'h01);
		wr(A, 8'h80);
		`CHK("engine_reset", 1'b1, cmd.engine_reset)
		`CHK("auth_enabled", 1'b0, auth_enabled)
		tick(1);
		`CHK("engine_reset", 1'b0, cmd.engine_reset)
		wr(A, 8'h20);
		`CHK("list_accepted", 1'b1, cmd.list_accepted)
		rd(A, 8'h00);
	endtask
	// key acceptance, zero write, clear on key ready, repeater gate
	task automatic t_key;
		`CHK("auth_continue", 1'b0, auth_continue)
		wr(A, 8'h10);
		rd(A, 8'h10);
		`CHK("auth_continue", 1'b1, auth_continue)
		wr(A, 8'h00);
		rd(A, 8'h10);
		receiver_key_ready = 1'b1;
		tick(2);
		rd(A, 8'h00);
		`CHK("auth_continue", 1'b0, auth_continue)
		repeater_mode = 1'b1;
		tick(1);
		`CHK("auth_continue", 1'b1, auth_continue)
	endtask
	// key ready edge and a key-accepted write in one cycle: the set wins
	task automatic t_key_race;
		receiver_key_ready = 1'b0;
		tick(1);
		req = '{1'b1, 1'b0, A, 8'h10};
		receiver_key_ready = 1'b1;
		tick(1);
		req.wr = 1'b0;
		rd(A, 8'h10);
		receiver_key_ready = 1'b0;
		tick(1);
		receiver_key_ready = 1'b1;
		tick(2);
		rd(A, 8'h00);
	endtask
	// video selection by request, authentication and encryption-off
	task automatic t_video;
		wr(A, 8'h05);
		tick(2);
		`CHK("video_mode", VIDEO_BLUE, video_mode)
		authenticated = 1'b1;
		tick(2);
		`CHK("video_mode", VIDEO_ENCRYPTED, video_mode)
		// request kept set, so only the off bit can make the video plain
		wr(A, 8'h0C);
		tick(2);
		`CHK("video_mode", VIDEO_PLAIN, video_mode)
		`CHK("auth_enabled", 1'b1, auth_enabled)
		wr(A, 8'h04);
		tick(2);
		`CHK("video_mode", VIDEO_ENCRYPTED, video_mode)
		wr(A, 8'h00);
		tick(2);
		`CHK("video_mode", VIDEO_PLAIN, video_mode)
		policy = POLICY_ALWAYS;
		// a stored one here would show after the policy drops
		wr(A, 8'h04);
		rd(A, 8'h05);
		tick(1);
		`CHK("video_mode", VIDEO_ENCRYPTED, video_mode)
		policy = 2'h1;
		rd(A, 8'h01);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (12) @(posedge clock);
		#1;
		rstn = 1'b1;
		tick(3);
		t_reset();
		t_enable();
		t_off();
		t_key();
		t_key_race();
		t_video();
		close_out();
	end
endmodule
`default_nettype wire
